// [power_reset_boot_sequencer_test.sv]
`timescale 1ns/1ps
module power_reset_boot_sequencer_test;
    import prb_pkg::*;
    logic        mclk, arst_n, supply_up, rst_req, io_power_good, reset_input_n;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, boot_fetch_vaddr, boot_fetch_paddr;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        boot_type_select, boot_width_select, core_regulator_enable, reset_output_n;
    logic        static_chip_select_zero_en, sync_memory_chip_select_zero_en;
    logic        power_prepare, sleep_active, hw_reset_seen;
    prb_boot_t   boot_mode;
    int          bad_count, compares, n;
    prb_sequencer #(.VPUT_20MS_CYC(25'd50), .VPUT_5MS_CYC(25'd40),
        .VPUT_100MS_CYC(25'd60)) i_dut (.*);
    prb_supervisor i_sup (.mclk(mclk), .supply_up(supply_up), .rst_req(rst_req),
        .io_power_good(io_power_good), .reset_input_n(reset_input_n));
    // ==========================================================
    // Shared tasks
    task automatic chk(input bit ok, input string msg);
        compares++;
        if (!ok)
        begin
            bad_count++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    // Expected status word: regulator on, synchronous boot, given state.
    function automatic logic [31:0] st_word(input prb_state_t s);
        return (32'h1 << ST_CRE_BIT) | (32'(BOOT_SROM32) << ST_BOOT_LSB) | 32'(s);
    endfunction
    task automatic wt(ref logic s, input logic v, output int k);
        k = 0;
        while (s !== v && k < 2000)
        begin
            @(posedge mclk);
            k++;
        end
    endtask
    task automatic axw(input logic [11:0] a, input logic [1:0] rsp);
        int k = 0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            k++;
        end
        while (s_axi_bvalid !== 1'b1 && k < 50);
        s_axi_bready <= 1'b0;
        chk(s_axi_bvalid === 1'b1 && s_axi_bresp === rsp, "write response");
    endtask
    task automatic axr(input logic [11:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            k++;
        end
        while (s_axi_rvalid !== 1'b1 && k < 50);
        s_axi_rready <= 1'b0;
        chk(s_axi_rvalid === 1'b1 && s_axi_rdata === d && s_axi_rresp === RESP_OKAY, "read data");
    endtask
    task automatic tally_and_finish();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========================================================
    // Stimulus
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial
    begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        tally_and_finish();
    end
    // ==========================================================
    // Scenarios
    task automatic power_up_boot();
        chk(core_regulator_enable === 1'b0 && reset_output_n === 1'b0, "not idle");
        axr(REG_PWR_CTRL, 32'h0);
        supply_up <= 1'b1;
        wt(core_regulator_enable, 1'b1, n);
        chk(n <= 6, "enable late");
        wt(reset_output_n, 1'b1, n);
        chk(n >= 170 && n <= 200, "boot release time");
        chk(boot_mode === BOOT_SROM32 && hw_reset_seen === 1'b1, "boot kind");
        chk(sync_memory_chip_select_zero_en === 1'b1, "sync select");
        chk(static_chip_select_zero_en === 1'b0, "static select");
        chk(boot_fetch_vaddr === BOOT_FETCH_VADDR, "fetch vaddr");
        chk(boot_fetch_paddr === BOOT_FETCH_PADDR, "fetch paddr");
        axr(REG_STATUS, st_word(ST_RUN) | (32'h1 << ST_HWRST_BIT));
    endtask
    task automatic runtime_reset();
        axw(REG_PWR_CTRL, RESP_OKAY);
        rst_req <= 1'b1;
        wt(reset_output_n, 1'b0, n);
        chk(n <= 7, "fall late");
        repeat (220) @(posedge mclk);
        chk(core_regulator_enable === 1'b1, "enable dropped");
        rst_req <= 1'b0;
        wt(reset_output_n, 1'b1, n);
        chk(n <= 127 && hw_reset_seen === 1'b0, "runtime release");
        axr(REG_PWR_CTRL, 32'h0000_000a);
    endtask
    task automatic sleep_cycle();
        axw(12'hffc, RESP_SLVERR);
        axw(REG_SLEEP_PREPARE, RESP_OKAY);
        @(posedge mclk);
        chk(power_prepare === 1'b1 && sleep_active === 1'b0, "prepare flag");
        axw(REG_SLEEP_ENTRY, RESP_OKAY);
        repeat (6) @(posedge mclk);
        chk(sleep_active === 1'b1 && reset_output_n === 1'b0, "sleep entry");
        chk(core_regulator_enable === 1'b0, "core on in sleep");
        // Wake by reset: ramp with the retained power-up code, then hold.
        rst_req <= 1'b1;
        repeat (60) @(posedge mclk);
        axr(REG_STATUS, st_word(ST_RAMP));
        repeat (10) @(posedge mclk);
        axr(REG_STATUS, st_word(ST_HOLD));
        repeat (150) @(posedge mclk);
        rst_req <= 1'b0;
        wt(reset_output_n, 1'b1, n);
        chk(n <= 127 && sleep_active === 1'b0 && power_prepare === 1'b0, "wake");
    endtask
    task automatic power_loss_in_reset();
        rst_req <= 1'b1;
        repeat (20) @(posedge mclk);
        supply_up <= 1'b0;
        repeat (220) @(posedge mclk);
        chk(core_regulator_enable === 1'b0 && reset_output_n === 1'b0, "power loss");
        chk(power_prepare === 1'b0 && sleep_active === 1'b0, "flags kept");
        axr(REG_PWR_CTRL, 32'h0);
        // Straps only move while the device is unpowered.
        {boot_type_select, boot_width_select} <= 2'h1;
        supply_up <= 1'b1;
        rst_req <= 1'b0;
        wt(reset_output_n, 1'b1, n);
        chk(n >= 170 && n <= 205 && hw_reset_seen === 1'b1, "hardware reset");
        chk(boot_mode === BOOT_ROM16 && static_chip_select_zero_en === 1'b1, "rom boot");
        chk(sync_memory_chip_select_zero_en === 1'b0, "sync select on");
    endtask
    initial
    begin
        {arst_n, supply_up, rst_req, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        {boot_type_select, boot_width_select} = 2'h2;
        {s_axi_wstrb, s_axi_wdata} = 36'hfa5a5_5a5a;
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (20) @(posedge mclk);
        power_up_boot();
        runtime_reset();
        sleep_cycle();
        power_loss_in_reset();
        tally_and_finish();
    end
endmodule // power_reset_boot_sequencer_test

// [prb_pkg.sv]
package prb_pkg;

    // ==========================================================
    // Clock and timing
    localparam longint unsigned CLK_PERIOD_NS   = 5;
    localparam longint unsigned T_VPUT_20MS_NS  = 20_000_000;
    localparam longint unsigned T_VPUT_5MS_NS   = 5_000_000;
    localparam longint unsigned T_VPUT_100MS_NS = 100_000_000;
    localparam longint unsigned T_VPUT_2US_NS   = 2_000;
    localparam longint unsigned T_VRO_MIN_NS    = 600;
    localparam longint unsigned T_VRO_MAX_NS    = 750;
    localparam longint unsigned T_ROF_BASE_NS   = 25;
    localparam longint unsigned T_ROF_MAX_NS    = T_ROF_BASE_NS + CLK_PERIOD_NS;
    localparam longint unsigned ROR_CLK_COUNT   = 120;
    localparam longint unsigned T_ROR_MAX_NS    = T_ROF_MAX_NS + ROR_CLK_COUNT * CLK_PERIOD_NS;

    localparam int unsigned TMR_W = 25;
    localparam logic [TMR_W-1:0] VPUT_20MS_CYC  =
        TMR_W'((T_VPUT_20MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] VPUT_5MS_CYC   =
        TMR_W'((T_VPUT_5MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] VPUT_100MS_CYC =
        TMR_W'((T_VPUT_100MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] VPUT_2US_CYC   =
        TMR_W'((T_VPUT_2US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] VRO_MIN_CYC    =
        TMR_W'((T_VRO_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] VRO_MAX_CYC    = TMR_W'(T_VRO_MAX_NS / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] ROF_MAX_CYC    = TMR_W'(T_ROF_MAX_NS / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] ROR_MAX_CYC    = TMR_W'(T_ROR_MAX_NS / CLK_PERIOD_NS);

    // ==========================================================
    // Register map and fields
    localparam int unsigned ADDR_W = 12;
    localparam logic [ADDR_W-1:0] REG_PWR_CTRL      = 12'h03c;
    localparam logic [ADDR_W-1:0] REG_SLEEP_PREPARE = 12'h078;
    localparam logic [ADDR_W-1:0] REG_SLEEP_ENTRY   = 12'h07c;
    localparam logic [ADDR_W-1:0] REG_STATUS        = 12'h080;
    localparam int unsigned PWR_CTRL_W   = 4;
    localparam int unsigned PWR_VPUT_LSB = 2;
    localparam logic [PWR_CTRL_W-1:0] PWR_CTRL_RST = 4'h0;
    localparam int unsigned ST_FSM_LSB   = 0;
    localparam int unsigned ST_BOOT_LSB  = 8;
    localparam int unsigned ST_HWRST_BIT = 10;
    localparam int unsigned ST_PREP_BIT  = 11;
    localparam int unsigned ST_SLEEP_BIT = 12;
    localparam int unsigned ST_CRE_BIT   = 13;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Boot
    localparam logic [31:0] BOOT_FETCH_VADDR = 32'hbfc0_0000;
    localparam logic [31:0] BOOT_FETCH_PADDR = 32'h1fc0_0000;

    typedef enum logic [1:0] {
        BOOT_ROM32  = 2'h0,
        BOOT_ROM16  = 2'h1,
        BOOT_SROM32 = 2'h2,
        BOOT_RSVD   = 2'h3
    } prb_boot_t;

    typedef enum logic [5:0] {
        ST_OFF    = 6'h01,
        ST_RAMP   = 6'h02,
        ST_HOLD   = 6'h04,
        ST_SETTLE = 6'h08,
        ST_RUN    = 6'h10,
        ST_SLEEP  = 6'h20
    } prb_state_t;

endpackage

// [prb_sequencer.sv]
`timescale 1ns/1ps
module prb_sequencer #(
    parameter logic [prb_pkg::TMR_W-1:0] VPUT_20MS_CYC  = prb_pkg::VPUT_20MS_CYC,
    parameter logic [prb_pkg::TMR_W-1:0] VPUT_5MS_CYC   = prb_pkg::VPUT_5MS_CYC,
    parameter logic [prb_pkg::TMR_W-1:0] VPUT_100MS_CYC = prb_pkg::VPUT_100MS_CYC
) (
    input  wire logic                        mclk,
    input  wire logic                        arst_n,
    input  wire logic [prb_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [prb_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    input  wire logic                        io_power_good,
    input  wire logic                        reset_input_n,
    input  wire logic                        boot_type_select,
    input  wire logic                        boot_width_select,
    output logic                             core_regulator_enable,
    output logic                             reset_output_n,
    output prb_pkg::prb_boot_t               boot_mode,
    output logic                             static_chip_select_zero_en,
    output logic                             sync_memory_chip_select_zero_en,
    output logic [31:0]                      boot_fetch_vaddr,
    output logic [31:0]                      boot_fetch_paddr,
    output logic                             power_prepare,
    output logic                             sleep_active,
    output logic                             hw_reset_seen
);
    import prb_pkg::*;

    // ==========================================================
    // Pin synchronisation
    logic [3:0]       pins_s;
    logic             pg_s;
    logic             rin_s;
    logic [1:0]       boot_s;
    logic             pg_d;
    prb_state_t       st;
    prb_state_t       next_st;
    logic [PWR_CTRL_W-1:0] pwr_ctrl;
    logic             wr_prepare;
    logic             wr_sleep;
    prb_tmr_if        tmr_bus ();

    prb_sync #(.W(4)) u_sync (
        .mclk   (mclk),
        .arst_n (arst_n),
        .d      ({io_power_good, reset_input_n, boot_type_select, boot_width_select}),
        .q      (pins_s)
    );

    assign pg_s   = pins_s[3];
    assign rin_s  = pins_s[2];
    assign boot_s = pins_s[1:0];

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pg_d  <= 1'b0;
        end
        else
        begin
            pg_d  <= pg_s;
        end
    end

    prb_timer u_timer (
        .mclk   (mclk),
        .arst_n (arst_n),
        .t      (tmr_bus)
    );

    function automatic logic [TMR_W-1:0] vput_cycles(input logic [1:0] code);
        case (code)
            2'h0:    vput_cycles = VPUT_20MS_CYC;
            2'h1:    vput_cycles = VPUT_5MS_CYC;
            2'h2:    vput_cycles = VPUT_100MS_CYC;
            default: vput_cycles = VPUT_2US_CYC;
        endcase
    endfunction

    // ==========================================================
    // Sequencer
    always_comb
    begin
        next_st = st;
        case (st)
            ST_OFF:    next_st = pg_s ? ST_RAMP : ST_OFF;
            ST_RAMP:   next_st = tmr_bus.done ? ST_HOLD : ST_RAMP;
            ST_HOLD:   next_st = rin_s ? ST_SETTLE : ST_HOLD;
            ST_SETTLE:
            begin
                if (!rin_s)
                    next_st = ST_HOLD;
                else if (tmr_bus.done)
                    next_st = ST_RUN;
            end
            ST_RUN:
            begin
                if (!rin_s)
                    next_st = ST_HOLD;
                else if (wr_sleep)
                    next_st = ST_SLEEP;
            end
            ST_SLEEP:
            begin
                if (!rin_s)
                    next_st = power_prepare ? ST_RAMP : ST_HOLD;
            end
            default:   next_st = ST_OFF;
        endcase
        if (!pg_s)
            next_st = ST_OFF;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            st <= ST_OFF;
        else
            st <= next_st;
    end

    // Timer starts on entry to the ramp and the settle states.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tmr_bus.start <= 1'b0;
            tmr_bus.load  <= '0;
        end
        else
        begin
            tmr_bus.start <= (next_st == ST_RAMP && st != ST_RAMP)
                          || (next_st == ST_SETTLE && st != ST_SETTLE);
            tmr_bus.load  <= (next_st == ST_RAMP)
                          ? vput_cycles(pwr_ctrl[PWR_VPUT_LSB +: 2])
                          : VRO_MIN_CYC;
        end
    end

    // Pin outputs follow the next state so they stand with the state.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            core_regulator_enable <= 1'b0;
            reset_output_n        <= 1'b0;
            sleep_active          <= 1'b0;
        end
        else
        begin
            core_regulator_enable <= (next_st != ST_OFF)
                                  && !(next_st == ST_SLEEP && power_prepare);
            reset_output_n        <= (next_st == ST_RUN);
            sleep_active          <= (next_st == ST_SLEEP);
        end
    end

    // Hardware-reset marker: set on a power-good rise, cleared by a runtime reset.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            hw_reset_seen <= 1'b0;
        else if (pg_s && !pg_d)
            hw_reset_seen <= 1'b1;
        else if (st == ST_RUN && !rin_s)
            hw_reset_seen <= 1'b0;
    end

    // Sleep preparation flag; a new write wins over the clear on wake.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            power_prepare <= 1'b0;
        else if (wr_prepare)
            power_prepare <= 1'b1;
        else if ((st == ST_SLEEP && next_st != ST_SLEEP) || !pg_s)
            power_prepare <= 1'b0;
    end

    // Boot source is latched at each release of the reset input.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            boot_mode                       <= BOOT_ROM32;
            static_chip_select_zero_en      <= 1'b0;
            sync_memory_chip_select_zero_en <= 1'b0;
            boot_fetch_vaddr                <= '0;
            boot_fetch_paddr                <= '0;
        end
        else if (st == ST_HOLD && rin_s)
        begin
            boot_mode                       <= prb_boot_t'(boot_s);
            static_chip_select_zero_en      <= !boot_s[1];
            sync_memory_chip_select_zero_en <= (boot_s == BOOT_SROM32);
            boot_fetch_vaddr                <= BOOT_FETCH_VADDR;
            boot_fetch_paddr                <= BOOT_FETCH_PADDR;
        end
    end

    // ==========================================================
    // Register bus
    logic                aw_got;
    logic                w_got;
    logic [ADDR_W-1:0]   aw_addr;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                do_write;

    assign do_write = aw_got && w_got && !s_axi_bvalid;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            aw_addr       <= '0;
            w_data        <= '0;
            w_strb        <= '0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                s_axi_awready <= 1'b0;
                aw_got        <= 1'b1;
                aw_addr       <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                s_axi_wready <= 1'b0;
                w_got        <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr == REG_PWR_CTRL || aw_addr == REG_SLEEP_PREPARE
                              || aw_addr == REG_SLEEP_ENTRY) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                aw_got        <= 1'b0;
                w_got         <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Write side effects; the written data of both sleep registers is ignored.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_prepare <= 1'b0;
            wr_sleep   <= 1'b0;
        end
        else
        begin
            wr_prepare <= do_write && aw_addr == REG_SLEEP_PREPARE;
            wr_sleep   <= do_write && aw_addr == REG_SLEEP_ENTRY;
        end
    end

    // Power control survives a runtime reset and sleep, cleared when power good drops.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            pwr_ctrl <= PWR_CTRL_RST;
        else if (!pg_s)
            pwr_ctrl <= PWR_CTRL_RST;
        else if (do_write && aw_addr == REG_PWR_CTRL && w_strb[0])
            pwr_ctrl <= w_data[PWR_CTRL_W-1:0];
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
            case (s_axi_araddr)
                REG_PWR_CTRL:      s_axi_rdata[PWR_CTRL_W-1:0] <= pwr_ctrl;
                REG_SLEEP_PREPARE: s_axi_rdata <= '0;
                REG_SLEEP_ENTRY:   s_axi_rdata <= '0;
                REG_STATUS:
                begin
                    s_axi_rdata[ST_FSM_LSB +: 6]  <= st;
                    s_axi_rdata[ST_BOOT_LSB +: 2] <= boot_mode;
                    s_axi_rdata[ST_HWRST_BIT]     <= hw_reset_seen;
                    s_axi_rdata[ST_PREP_BIT]      <= power_prepare;
                    s_axi_rdata[ST_SLEEP_BIT]     <= sleep_active;
                    s_axi_rdata[ST_CRE_BIT]       <= core_regulator_enable;
                end
                default:           s_axi_rresp <= RESP_SLVERR;
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ==========================================================
    // Checks
    logic [TMR_W-1:0] ramp_cnt;
    logic [TMR_W-1:0] settle_cnt;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ramp_cnt   <= '0;
            settle_cnt <= '0;
        end
        else
        begin
            ramp_cnt   <= (st == ST_RAMP) ? ramp_cnt + TMR_W'(1) : '0;
            settle_cnt <= (st == ST_SETTLE) ? settle_cnt + TMR_W'(1) : '0;
        end
    end

    AST_PREPARE_SET: assert property (@(posedge mclk) disable iff (!arst_n)
        do_write && aw_addr == REG_SLEEP_PREPARE |-> ##2 power_prepare)
        else $error("Prepare write did not set the prepare flag.");
    AST_SLEEP_ENTRY: assert property (@(posedge mclk) disable iff (!arst_n)
        do_write && aw_addr == REG_SLEEP_ENTRY && st == ST_RUN && rin_s && pg_s
        ##1 (rin_s && pg_s) |-> ##[1:2] sleep_active)
        else $error("Sleep write did not enter sleep.");
    AST_CRE_AFTER_PG: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(core_regulator_enable) |-> $past(pg_s))
        else $error("Regulator enabled without power good.");
    AST_VPUT_WAIT: assert property (@(posedge mclk) disable iff (!arst_n)
        st == ST_RAMP && next_st == ST_HOLD |-> ramp_cnt >= vput_cycles(pwr_ctrl[3:2]))
        else $error("Core ramp left before the power-up time.");
    AST_VPUT_CLEAR: assert property (@(posedge mclk) disable iff (!arst_n)
        !pg_s |=> pwr_ctrl == PWR_CTRL_RST)
        else $error("Power control not cleared by hardware reset.");
    AST_HW_KIND: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(pg_s) |=> hw_reset_seen)
        else $error("Hardware reset not recognised.");
    AST_RT_KEEP: assert property (@(posedge mclk) disable iff (!arst_n)
        st == ST_RUN && !rin_s && pg_s |=> core_regulator_enable && !reset_output_n)
        else $error("Runtime reset dropped the regulator enable.");
    AST_VRO: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(reset_output_n) |-> $past(settle_cnt) >= VRO_MIN_CYC
        && $past(settle_cnt) <= VRO_MAX_CYC)
        else $error("Reset output released outside the settle window.");
    AST_ROF: assert property (@(posedge mclk) disable iff (!arst_n)
        $fell(rin_s) && reset_output_n |-> ##1 !reset_output_n)
        else $error("Reset output late after reset input fell.");
    AST_ROR: assert property (@(posedge mclk) disable iff (!arst_n)
        st == ST_HOLD && rin_s && pg_s ##1 (rin_s && pg_s)[*8]
        |-> ##[1:118] (reset_output_n || !rin_s || !pg_s || wr_sleep))
        else $error("Reset output late after reset input rose.");
    AST_BOOT_CS: assert property (@(posedge mclk) disable iff (!arst_n)
        st == ST_RUN |-> static_chip_select_zero_en == !boot_mode[1]
        && sync_memory_chip_select_zero_en == (boot_mode == BOOT_SROM32))
        else $error("Boot chip select does not match boot mode.");

    COV_BOOT_UP: cover property (@(posedge mclk) disable iff (!arst_n)
        $rose(reset_output_n) && hw_reset_seen);
    COV_RUNTIME: cover property (@(posedge mclk) disable iff (!arst_n)
        $rose(reset_output_n) && !hw_reset_seen);
    COV_SLEEP: cover property (@(posedge mclk) disable iff (!arst_n)
        $rose(sleep_active) && power_prepare);
endmodule // prb_sequencer

// [prb_supervisor.sv]
`timescale 1ns/1ps
module prb_supervisor (
    input  wire logic mclk,
    input  wire logic supply_up,
    input  wire logic rst_req,
    output logic      io_power_good,
    output logic      reset_input_n
);
    // Power good follows the I/O supply; the bench keeps each low phase long.
    always_ff @(posedge mclk) io_power_good <= supply_up;
    // Reset input is released only once power good is already high.
    always_ff @(posedge mclk) reset_input_n <= io_power_good && supply_up && !rst_req;
endmodule // prb_supervisor

// [prb_sync.sv]
`timescale 1ns/1ps
module prb_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         mclk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta <= '0;
            q    <= '0;
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // prb_sync

// [prb_timer.sv]
`timescale 1ns/1ps
module prb_timer (
    input wire logic mclk,
    input wire logic arst_n,
    prb_tmr_if.tmr   t
);
    import prb_pkg::*;

    logic [TMR_W-1:0] cnt;
    logic             busy;

    // A new start always reloads, so a stale count never fires.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt    <= '0;
            busy   <= 1'b0;
            t.done <= 1'b0;
        end
        else if (t.start)
        begin
            cnt    <= t.load;
            busy   <= 1'b1;
            t.done <= 1'b0;
        end
        else if (busy && cnt <= TMR_W'(1))
        begin
            busy   <= 1'b0;
            t.done <= 1'b1;
        end
        else
        begin
            cnt    <= busy ? cnt - TMR_W'(1) : cnt;
            t.done <= 1'b0;
        end
    end
endmodule // prb_timer

// [prb_tmr_if.sv]
`timescale 1ns/1ps
interface prb_tmr_if;
    import prb_pkg::*;
    logic             start;
    logic [TMR_W-1:0] load;
    logic             done;
    modport ctl (output start, output load, input done);
    modport tmr (input start, input load, output done);
endinterface
